// ==== rtl/ebda_pkg.sv ====
package ebda_pkg;

    // *****************************
    // address and size coding
    // *****************************
    localparam int ADDR_W = 24;
    localparam int AREA_MSB = 23;
    localparam int AREA_LSB = 21;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // *****************************
    // access state counts
    // *****************************
    localparam logic [2:0] BASE_2ST = 3'h2;
    localparam logic [2:0] BASE_3ST = 3'h3;
    localparam logic [2:0] BURST_1ST = 3'h1;
    localparam logic [2:0] BURST_2ST = 3'h2;
    // pin data reaches the assembler two edges late
    localparam logic [1:0] SYNC_LAT = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PREP,
        ST_GAP,
        ST_ACC,
        ST_WCAP,
        ST_ACK
    } ebda_state_type;

endpackage : ebda_pkg

// ==== rtl/ebda_arb_if.sv ====
`timescale 1ns/1ps
interface ebda_arb_if;
    logic cpu_req;
    logic dtc_req;
    logic busy;
    logic gnt_cpu;
    logic gnt_dtc;

    modport ctl (output cpu_req, output dtc_req, output busy, input gnt_cpu, input gnt_dtc);
    modport arb (input cpu_req, input dtc_req, input busy, output gnt_cpu, output gnt_dtc);
endinterface : ebda_arb_if

// ==== rtl/ebda_arbiter.sv ====
`timescale 1ns/1ps
module ebda_arbiter
    import ebda_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // masters and owner
    ebda_arb_if.arb bus
);

    // *****************************
    // ownership
    // *****************************
    // grant moves only while the controller is free, so a split transfer keeps its owner
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus.gnt_cpu <= 1'b1;
            bus.gnt_dtc <= 1'b0;
        end else if (!bus.busy) begin
            if (bus.dtc_req) begin
                bus.gnt_cpu <= 1'b0;
                bus.gnt_dtc <= 1'b1;
            end else if (bus.cpu_req) begin
                bus.gnt_cpu <= 1'b1;
                bus.gnt_dtc <= 1'b0;
            end
        end
    end

    // *****************************
    // checks
    // *****************************
    property p_one_owner;
        @(posedge core_clk) disable iff (!resetn)
        bus.gnt_cpu != bus.gnt_dtc;
    endproperty
    a_one_owner: assert property (p_one_owner) else $error("two or no bus owners");

    property p_hold_busy;
        @(posedge core_clk) disable iff (!resetn)
        bus.busy |=> $stable(bus.gnt_dtc);
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("grant moved while busy");

endmodule : ebda_arbiter

// ==== rtl/ebda_top.sv ====
`timescale 1ns/1ps
module ebda_top
    import ebda_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // processor request
    input wire logic cpu_req,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [1:0] cpu_size,
    input wire logic cpu_write,
    input wire logic [31:0] cpu_wdata,
    output logic cpu_ack,
    // transfer controller request
    input wire logic dtc_req,
    input wire logic [ADDR_W-1:0] dtc_addr,
    input wire logic [1:0] dtc_size,
    input wire logic dtc_write,
    input wire logic [31:0] dtc_wdata,
    output logic dtc_ack,
    output logic [31:0] rdata,
    // area setup
    input wire logic [7:0] area_wide,
    input wire logic [7:0] area_slow,
    input wire logic [15:0] area_waits,
    input wire logic [7:0] area_burst,
    input wire logic burst_slow,
    input wire logic idle_en,
    // external bus
    output logic [ADDR_W-1:0] ext_addr,
    output logic ext_rd_n,
    output logic ext_wr_hi_n,
    output logic ext_wr_lo_n,
    input wire logic [15:0] ext_data_in,
    output logic [15:0] ext_data_out,
    output logic ext_data_oe_hi,
    output logic ext_data_oe_lo
);

    // *****************************
    // helpers
    // *****************************
    function automatic logic [2:0] n_acc(input logic wide, input logic [1:0] size);
        if (wide) n_acc = (size == SZ_LONG) ? 3'h2 : 3'h1;
        else n_acc = (size == SZ_LONG) ? 3'h4 : ((size == SZ_WORD) ? 3'h2 : 3'h1);
    endfunction : n_acc

    function automatic logic [2:0] n_bytes(input logic [1:0] size);
        n_bytes = (size == SZ_LONG) ? 3'h4 : ((size == SZ_WORD) ? 3'h2 : 3'h1);
    endfunction : n_bytes

    function automatic logic [7:0] pick(input logic [31:0] d, input logic [2:0] idx);
        pick = d[{idx[1:0], 3'b000} +: 8];
    endfunction : pick

    // *****************************
    // arbitration
    // *****************************
    ebda_state_type state_r;
    logic take;
    ebda_arb_if arb ();

    // transfer controller wins a tie: the processor waits while it asks
    assign take = (state_r == ST_IDLE)
                && ((arb.gnt_cpu && cpu_req && !dtc_req) || (arb.gnt_dtc && dtc_req));
    assign arb.cpu_req = cpu_req;
    assign arb.dtc_req = dtc_req;
    assign arb.busy = (state_r != ST_IDLE) || take;

    ebda_arbiter u_arb (
        .core_clk(core_clk),
        .resetn(resetn),
        .bus(arb.arb)
    );

    // *****************************
    // latched transfer
    // *****************************
    logic [ADDR_W-1:0] op_addr_r;
    logic [1:0] op_size_r;
    logic op_write_r, op_dtc_r, op16_r, op3_r, opb_r;
    logic [1:0] opw_r;
    logic [31:0] op_wdata_r;
    logic [2:0] area;
    logic [ADDR_W-1:0] m_addr;

    assign m_addr = arb.gnt_dtc ? dtc_addr : cpu_addr;
    assign area = m_addr[AREA_MSB:AREA_LSB];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            op_addr_r <= '0;
            op_size_r <= SZ_BYTE;
            op_write_r <= 1'b0;
            op_wdata_r <= '0;
            op_dtc_r <= 1'b0;
            op16_r <= 1'b0;
            op3_r <= 1'b0;
            opw_r <= 2'h0;
            opb_r <= 1'b0;
        end else if (take) begin
            op_addr_r <= m_addr;
            op_size_r <= arb.gnt_dtc ? dtc_size : cpu_size;
            op_write_r <= arb.gnt_dtc ? dtc_write : cpu_write;
            op_wdata_r <= arb.gnt_dtc ? dtc_wdata : cpu_wdata;
            op_dtc_r <= arb.gnt_dtc;
            op16_r <= area_wide[area];
            op3_r <= area_slow[area];
            opw_r <= area_waits[{area, 1'b0} +: 2];
            opb_r <= area_burst[area];
        end
    end

    // *****************************
    // access launch decode
    // *****************************
    logic [2:0] off_r, left_r, cnt_r, cur_len_r, len_cnt_r, acc_cnt_r, la_len, la_idx;
    logic first_r, last_rd_r, cur_hi_r, cur_two_r;
    logic unit_two, la_hi, la_lo, need_idle, acc_end, launch, burst_now;
    logic [ADDR_W-1:0] la_addr;
    logic [15:0] la_data;

    assign unit_two = op16_r && (op_size_r != SZ_BYTE);
    assign la_addr = op_addr_r + {{(ADDR_W-3){1'b0}}, off_r};
    assign la_hi = unit_two || !op16_r || !la_addr[0];
    assign la_lo = unit_two || (op16_r && la_addr[0]);
    assign la_idx = n_bytes(op_size_r) - 3'h1 - off_r;
    assign la_data = unit_two ? {pick(op_wdata_r, la_idx), pick(op_wdata_r, la_idx - 3'h1)}
                              : {2{pick(op_wdata_r, la_idx)}};
    assign burst_now = opb_r && !op_write_r && !first_r;
    // waits stretch the 3-state cycle only
    assign la_len = burst_now ? (burst_slow ? BURST_2ST : BURST_1ST)
                  : (op3_r ? BASE_3ST + {1'b0, opw_r} : BASE_2ST);
    assign need_idle = idle_en && last_rd_r && op_write_r;
    assign acc_end = (state_r == ST_ACC) && (cnt_r == 3'h0);
    assign launch = ((state_r == ST_PREP) && !need_idle) || (state_r == ST_GAP)
                  || (acc_end && (left_r != 3'h0));

    // *****************************
    // sequencer
    // *****************************
    logic [1:0] wcnt_r;
    logic ack_r, ack_set, cpu_ack_r, dtc_ack_r;
    logic [31:0] rdata_r, rbuf_r, nxt_rbuf;
    logic p1_v_r, p1_two_r, p1_hi_r, p2_v_r, p2_two_r, p2_hi_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            wcnt_r <= 2'h0;
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: if (take) state_r <= ST_PREP;
                ST_PREP: state_r <= need_idle ? ST_GAP : ST_ACC;
                ST_GAP: state_r <= ST_ACC;
                ST_ACC: begin
                    if (acc_end && left_r == 3'h0) begin
                        state_r <= op_write_r ? ST_ACK : ST_WCAP;
                        ack_r <= op_write_r;
                        wcnt_r <= 2'h0;
                    end
                end
                ST_WCAP: begin
                    wcnt_r <= wcnt_r + 2'h1;
                    if (wcnt_r == SYNC_LAT - 2'h1) begin
                        state_r <= ST_ACK;
                        ack_r <= 1'b1;
                        rdata_r <= nxt_rbuf;
                    end
                end
                ST_ACK: begin
                    state_r <= ST_IDLE;
                    ack_r <= 1'b0;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            off_r <= 3'h0;
            left_r <= 3'h0;
            cnt_r <= 3'h0;
            first_r <= 1'b0;
            last_rd_r <= 1'b0;
            cur_hi_r <= 1'b0;
            cur_two_r <= 1'b0;
            cur_len_r <= 3'h0;
        end else if (take) begin
            off_r <= 3'h0;
            first_r <= 1'b1;
        end else if (launch) begin
            off_r <= off_r + (unit_two ? 3'h2 : 3'h1);
            left_r <= first_r ? n_acc(op16_r, op_size_r) - 3'h1 : left_r - 3'h1;
            cnt_r <= la_len - 3'h1;
            cur_len_r <= la_len;
            first_r <= 1'b0;
            last_rd_r <= !op_write_r;
            cur_hi_r <= la_hi;
            cur_two_r <= unit_two;
        end else if (state_r == ST_ACC) begin
            cnt_r <= cnt_r - 3'h1;
        end
    end

    // *****************************
    // external pins
    // *****************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ext_addr <= '0;
            ext_rd_n <= 1'b1;
            ext_wr_hi_n <= 1'b1;
            ext_wr_lo_n <= 1'b1;
            ext_data_out <= '0;
            ext_data_oe_hi <= 1'b0;
            ext_data_oe_lo <= 1'b0;
        end else if (launch) begin
            ext_addr <= la_addr;
            ext_rd_n <= op_write_r;
            ext_wr_hi_n <= !(op_write_r && la_hi);
            ext_wr_lo_n <= !(op_write_r && la_lo);
            ext_data_out <= la_data;
            ext_data_oe_hi <= op_write_r && la_hi;
            ext_data_oe_lo <= op_write_r && la_lo;
        end else if (acc_end) begin
            ext_rd_n <= 1'b1;
            ext_wr_hi_n <= 1'b1;
            ext_wr_lo_n <= 1'b1;
            ext_data_oe_hi <= 1'b0;
            ext_data_oe_lo <= 1'b0;
        end
    end

    // *****************************
    // read capture
    // *****************************
    // pins pass two flops; the lane tags ride a matching two-stage pipe
    logic [15:0] din_s1_r, din_s2_r;

    assign nxt_rbuf = !p2_v_r ? rbuf_r
                    : (p2_two_r ? {rbuf_r[15:0], din_s2_r}
                                : {rbuf_r[23:0], p2_hi_r ? din_s2_r[15:8] : din_s2_r[7:0]});

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
            {p1_v_r, p1_two_r, p1_hi_r, p2_v_r, p2_two_r, p2_hi_r} <= '0;
            rbuf_r <= '0;
        end else begin
            din_s1_r <= ext_data_in;
            din_s2_r <= din_s1_r;
            p1_v_r <= acc_end && !op_write_r;
            p1_two_r <= cur_two_r;
            p1_hi_r <= cur_hi_r;
            {p2_v_r, p2_two_r, p2_hi_r} <= {p1_v_r, p1_two_r, p1_hi_r};
            rbuf_r <= take ? 32'h0 : nxt_rbuf;
        end
    end

    // per-master acknowledge flops, so the outputs come straight from flops
    assign ack_set = (acc_end && left_r == 3'h0 && op_write_r)
                   || (state_r == ST_WCAP && wcnt_r == SYNC_LAT - 2'h1);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_ack_r <= 1'b0;
            dtc_ack_r <= 1'b0;
        end else begin
            cpu_ack_r <= ack_set && !op_dtc_r;
            dtc_ack_r <= ack_set && op_dtc_r;
        end
    end

    assign cpu_ack = cpu_ack_r;
    assign dtc_ack = dtc_ack_r;
    assign rdata = rdata_r;

    // *****************************
    // checks
    // *****************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            len_cnt_r <= 3'h0;
            acc_cnt_r <= 3'h0;
        end else begin
            len_cnt_r <= launch ? 3'h1 : len_cnt_r + 3'h1;
            acc_cnt_r <= take ? 3'h0 : acc_cnt_r + {2'h0, launch};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_gap;
        state_r == ST_GAP && ext_rd_n && ext_wr_hi_n && ext_wr_lo_n;
    endsequence
    sequence s_wr_go;
        !ext_wr_hi_n || !ext_wr_lo_n;
    endsequence

    property p_lane8;
        (state_r != ST_IDLE && !op16_r) |-> ext_wr_lo_n && !ext_data_oe_lo;
    endproperty
    a_lane8: assert property (p_lane8) else $error("lower lane used in 8-bit area");

    property p_cnt8;
        (ack_r && !op16_r) |-> acc_cnt_r == n_acc(1'b0, op_size_r);
    endproperty
    a_cnt8: assert property (p_cnt8) else $error("wrong access count, 8-bit");

    property p_cnt16;
        (ack_r && op16_r) |-> acc_cnt_r == n_acc(1'b1, op_size_r);
    endproperty
    a_cnt16: assert property (p_cnt16) else $error("wrong access count, 16-bit");

    property p_odd_lane;
        (launch && op_write_r && op16_r && !unit_two) |=>
            (ext_wr_hi_n == ext_addr[0]) && (ext_wr_lo_n != ext_addr[0]);
    endproperty
    a_odd_lane: assert property (p_odd_lane) else $error("byte lane mismatch");

    property p_len;
        (acc_end && !(opb_r && !op_write_r && acc_cnt_r != 3'h1)) |->
            len_cnt_r == (op3_r ? BASE_3ST + {1'b0, opw_r} : BASE_2ST);
    endproperty
    a_len: assert property (p_len) else $error("basic access length wrong");

    property p_burst;
        (acc_end && opb_r && !op_write_r && acc_cnt_r != 3'h1) |->
            len_cnt_r == (burst_slow ? BURST_2ST : BURST_1ST);
    endproperty
    a_burst: assert property (p_burst) else $error("burst access length wrong");

    property p_idle;
        (state_r == ST_PREP && need_idle) |=> s_gap ##1 s_wr_go;
    endproperty
    a_idle: assert property (p_idle) else $error("no idle cycle before write");

    property p_ascend;
        (launch && !first_r) |=> ext_addr == $past(ext_addr) + (unit_two ? 24'h2 : 24'h1);
    endproperty
    a_ascend: assert property (p_ascend) else $error("split access not ascending");

    property p_ack_last;
        ack_r |-> left_r == 3'h0 && $past(state_r) inside {ST_ACC, ST_WCAP};
    endproperty
    a_ack_last: assert property (p_ack_last) else $error("early acknowledge");

endmodule : ebda_top

// ==== dv/ebda_mem_model.sv ====
`timescale 1ns/1ps
// ********************
// external rom and sram on the data pins
// ********************
module ebda_mem_model
    import ebda_pkg::*;
(
    // clock
    input wire logic core_clk,
    // area setup
    input wire logic [7:0] area_wide,
    // external bus
    input wire logic [ADDR_W-1:0] ext_addr,
    input wire logic ext_rd_n,
    input wire logic ext_wr_hi_n,
    input wire logic ext_wr_lo_n,
    input wire logic [15:0] ext_data_out,
    output logic [15:0] ext_data_in
);
    logic [7:0] mem [0:2047];
    logic [15:0] last_r = 16'h0000;
    logic wide;
    logic [10:0] hi_idx;
    logic [10:0] lo_idx;

    assign wide = area_wide[ext_addr[AREA_MSB:AREA_LSB]];
    // a narrow part hangs every byte on the upper lane
    assign hi_idx = wide ? {ext_addr[AREA_MSB:AREA_LSB], ext_addr[7:1], 1'b0} :
                    {ext_addr[AREA_MSB:AREA_LSB], ext_addr[7:0]};
    assign lo_idx = {ext_addr[AREA_MSB:AREA_LSB], ext_addr[7:1], 1'b1};
    // released pins never repeat the last value, so a late sample shows up
    assign ext_data_in = ext_rd_n ? ~last_r : {mem[hi_idx], wide ? mem[lo_idx] : ~last_r[7:0]};

    always @(posedge core_clk) begin
        if (!ext_rd_n) last_r <= ext_data_in;
        if (!ext_wr_hi_n) mem[hi_idx] <= ext_data_out[15:8];
        if (!ext_wr_lo_n && wide) mem[lo_idx] <= ext_data_out[7:0];
    end
endmodule : ebda_mem_model

// ==== dv/ebda_tb_top.sv ====
`timescale 1ns/1ps
module ebda_tb_top
    import ebda_pkg::*;
;
    // ********************
    // bench state
    // ********************
    logic core_clk, resetn, burst_slow, idle_en, ext_rd_n, ext_wr_hi_n, ext_wr_lo_n;
    logic oe_hi, oe_lo, last_rd, grant_dtc, prev_low;
    logic [1:0] req_v, wr_v, ack_v, cur_size;
    logic [ADDR_W-1:0] addr_v [2];
    logic [1:0] size_v [2];
    logic [31:0] wd_v [2];
    logic [31:0] rdata;
    logic [7:0] area_wide, area_slow, area_burst;
    logic [15:0] area_waits, ext_data_in, ext_data_out;
    logic [ADDR_W-1:0] ext_addr, prev_addr;
    logic [7:0] shadow [0:2047];
    logic [ADDR_W-1:0] acc_q [$];
    int err_total, num_checks;

    ebda_top DUT (.core_clk(core_clk), .resetn(resetn),
        .cpu_req(req_v[0]), .cpu_addr(addr_v[0]), .cpu_size(size_v[0]),
        .cpu_write(wr_v[0]), .cpu_wdata(wd_v[0]), .cpu_ack(ack_v[0]),
        .dtc_req(req_v[1]), .dtc_addr(addr_v[1]), .dtc_size(size_v[1]),
        .dtc_write(wr_v[1]), .dtc_wdata(wd_v[1]), .dtc_ack(ack_v[1]), .rdata(rdata),
        .area_wide(area_wide), .area_slow(area_slow), .area_waits(area_waits),
        .area_burst(area_burst), .burst_slow(burst_slow), .idle_en(idle_en),
        .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_hi_n(ext_wr_hi_n),
        .ext_wr_lo_n(ext_wr_lo_n), .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
        .ext_data_oe_hi(oe_hi), .ext_data_oe_lo(oe_lo));

    ebda_mem_model mem_model (.core_clk(core_clk), .area_wide(area_wide),
        .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_hi_n(ext_wr_hi_n),
        .ext_wr_lo_n(ext_wr_lo_n), .ext_data_out(ext_data_out), .ext_data_in(ext_data_in));

    // ********************
    // compare and expectation helpers
    // ********************
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    function automatic logic [10:0] idx(input logic [ADDR_W-1:0] a);
        return {a[AREA_MSB:AREA_LSB], a[7:0]};
    endfunction : idx

    function automatic logic [ADDR_W-1:0] ad(input logic [2:0] ar, input logic [7:0] off);
        return {ar, 13'h0, off};
    endfunction : ad

    function automatic int n_acc(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        if (!area_wide[a[AREA_MSB:AREA_LSB]]) return 1 << sz;
        return (sz == SZ_LONG) ? 2 : 1;
    endfunction : n_acc

    function automatic int exp_lat(input logic [ADDR_W-1:0] a, input logic [1:0] sz,
                                   input logic wr);
        logic [2:0] ar;
        int lat;
        ar = a[AREA_MSB:AREA_LSB];
        lat = (idle_en && last_rd && wr) ? 2 : 1;
        for (int i = 0; i < n_acc(a, sz); i++) begin
            if (area_burst[ar] && !wr && i > 0) lat += burst_slow ? 2 : 1;
            else if (area_slow[ar]) lat += 3 + int'(area_waits[2 * ar +: 2]);
            else lat += 2;
        end
        return wr ? lat : lat + 2;
    endfunction : exp_lat

    function automatic logic [31:0] exp_val(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < (1 << sz); i++) v = {v[23:0], shadow[idx(a + 24'(i))]};
        return v;
    endfunction : exp_val

    // ********************
    // transfer tasks
    // ********************
    task automatic check_acc(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        int step;
        step = area_wide[a[AREA_MSB:AREA_LSB]] ? 2 : 1;
        chk32(32'(acc_q.size()), 32'(n_acc(a, sz)));
        for (int i = 0; i < n_acc(a, sz) && acc_q.size() > 0; i++)
            chk32(32'(acc_q.pop_front()), 32'(a + 24'(i * step)));
        acc_q.delete();
    endtask : check_acc

    task automatic start(input logic m, input logic [ADDR_W-1:0] a, input logic [1:0] sz,
                         input logic wr, input logic [31:0] wd);
        cur_size = sz;
        addr_v[m] = a;
        size_v[m] = sz;
        wr_v[m] = wr;
        wd_v[m] = wd;
        req_v[m] = 1'b1;
    endtask : start

    task automatic finish(input logic m, input logic [ADDR_W-1:0] a, input logic [1:0] sz,
                          input logic wr, input logic [31:0] wd, input int lat);
        int n;
        logic [31:0] mk;
        n = 0;
        mk = (sz == SZ_BYTE) ? 32'hff : (sz == SZ_WORD) ? 32'hffff : 32'hffffffff;
        while (ack_v[m] !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        req_v[m] = 1'b0;
        chk1(ack_v[m], 1'b1);
        if (lat >= 0) chk32(32'(n), 32'(lat + 1));
        if (!wr) chk32(rdata & mk, exp_val(a, sz));
        for (int i = 0; i < (1 << sz) && wr; i++)
            shadow[idx(a + 24'(i))] = wd[8 * ((1 << sz) - 1 - i) +: 8];
        check_acc(a, sz);
        last_rd = !wr;
        grant_dtc = m;
        @(negedge core_clk);
        chk1(ack_v[m], 1'b0);
    endtask : finish

    task automatic do_xfer(input logic m, input logic [ADDR_W-1:0] a, input logic [1:0] sz,
                           input logic wr, input logic [31:0] wd);
        int lat;
        lat = exp_lat(a, sz, wr) + ((m != grant_dtc) ? 1 : 0);
        start(m, a, sz, wr, wd);
        finish(m, a, sz, wr, wd, lat);
    endtask : do_xfer

    // both masters at once: the controller goes first and keeps the bus to the end
    task automatic both_go(input logic [ADDR_W-1:0] a, input logic [1:0] sz, input logic wr,
                           input logic [31:0] wd);
        int lat;
        lat = exp_lat(a, sz, wr) + (grant_dtc ? 0 : 1);
        start(1'b1, a, sz, wr, wd);
        start(1'b0, a ^ 24'h80, sz, wr, ~wd);
        finish(1'b1, a, sz, wr, wd, lat);
        finish(1'b0, a ^ 24'h80, sz, wr, ~wd, -1);
    endtask : both_go

    task automatic rand_xfer(input logic both);
        logic [2:0] ar;
        logic [1:0] sz;
        logic wr;
        logic [ADDR_W-1:0] a;
        logic [31:0] wd;
        ar = 3'($urandom);
        sz = 2'($urandom % 3);
        wr = 1'($urandom) & ~area_burst[ar];
        a = ad(ar, 8'($urandom % 252) & ~8'((1 << sz) - 1));
        wd = $urandom >> (32 - 8 * (1 << sz));
        if (sz == SZ_LONG) wd = ~wd;
        if (both) both_go(a, sz, wr, wd);
        else do_xfer(1'($urandom), a, sz, wr, wd);
    endtask : rand_xfer

    // ********************
    // pin monitor
    // ********************
    always @(negedge core_clk) begin
        if (resetn) begin
            chk1(ack_v[0] & ack_v[1], 1'b0);
            if (!(ext_rd_n & ext_wr_hi_n & ext_wr_lo_n)) begin
                if (!prev_low || ext_addr !== prev_addr) acc_q.push_back(ext_addr);
                if (!area_wide[ext_addr[AREA_MSB:AREA_LSB]]) begin
                    chk1(ext_wr_lo_n & ~oe_lo, 1'b1);
                end else if (ext_rd_n && cur_size == SZ_BYTE) begin
                    chk1(ext_wr_hi_n, ext_addr[0]);
                    chk1(ext_wr_lo_n, ~ext_addr[0]);
                end else if (ext_rd_n) begin
                    chk1(ext_wr_hi_n | ext_wr_lo_n, 1'b0);
                end
            end
            prev_low = ~(ext_rd_n & ext_wr_hi_n & ext_wr_lo_n);
            prev_addr = ext_addr;
        end
    end

    // ********************
    // clock, watchdog, main sequence
    // ********************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        conclude();
    end

    initial begin
        void'($urandom(17351));
        {err_total, num_checks} = {32'h0, 32'h0};
        {resetn, req_v, wr_v, last_rd, grant_dtc, prev_low, cur_size} = 10'h0;
        for (int i = 0; i < 2; i++) begin
            addr_v[i] = 24'h0;
            size_v[i] = 2'h0;
            wd_v[i] = 32'h0;
        end
        for (int i = 0; i < 2048; i++) begin
            shadow[i] = 8'($urandom);
            mem_model.mem[i] = shadow[i];
        end
        area_wide = 8'hf0;
        area_slow = 8'h2c;
        area_waits = 16'h0480;
        area_burst = 8'h42;
        burst_slow = 1'b0;
        idle_en = 1'b1;
        repeat (8) @(negedge core_clk);
        resetn = 1'b1;
        @(negedge core_clk);
        do_xfer(1'b0, ad(3'h0, 8'h10), SZ_LONG, 1'b1, 32'h11223344);
        do_xfer(1'b0, ad(3'h0, 8'h10), SZ_LONG, 1'b0, 32'h0);
        do_xfer(1'b0, ad(3'h4, 8'h21), SZ_BYTE, 1'b1, 32'ha5);
        do_xfer(1'b0, ad(3'h4, 8'h20), SZ_WORD, 1'b0, 32'h0);
        do_xfer(1'b0, ad(3'h4, 8'h21), SZ_BYTE, 1'b0, 32'h0);
        do_xfer(1'b1, ad(3'h5, 8'h40), SZ_LONG, 1'b0, 32'h0);
        do_xfer(1'b1, ad(3'h1, 8'h80), SZ_LONG, 1'b0, 32'h0);
        do_xfer(1'b1, ad(3'h6, 8'h84), SZ_LONG, 1'b0, 32'h0);
        burst_slow = 1'b1;
        idle_en = 1'b0;
        do_xfer(1'b0, ad(3'h1, 8'h82), SZ_WORD, 1'b0, 32'h0);
        do_xfer(1'b0, ad(3'h3, 8'h02), SZ_WORD, 1'b1, 32'hbeef);
        both_go(ad(3'h2, 8'h08), SZ_WORD, 1'b1, 32'h1234);
        for (int k = 0; k < 48; k++) begin
            if (k % 8 == 0) begin
                area_wide = 8'($urandom);
                area_slow = 8'($urandom);
                area_waits = 16'($urandom);
                area_burst = 8'($urandom);
                burst_slow = 1'($urandom);
                idle_en = 1'($urandom);
            end
            rand_xfer(k % 8 == 7);
        end
        conclude();
    end
endmodule : ebda_tb_top
